// ---- core/snbfe_pkg.sv ----
// Package of constants and types for the serial NAND bus front end.
// Assumes a 20 MHz system clock that oversamples the host serial clock.
package snbfe_pkg;

  // ----------------------------------------------------------------
  // Address map
  // ----------------------------------------------------------------
  localparam int COL_ADDR_WIDTH = 12;
  localparam logic [11:0] COL_LAST_ECC_OFF = 12'd2175;
  localparam logic [11:0] COL_LAST_ECC_ON = 12'd2111;
  localparam logic [11:0] SPARE_FIRST = 12'd2048;
  localparam logic [11:0] SPARE_PROG_LAST_ECC_ON = 12'd2111;
  localparam int ROW_ADDR_WIDTH = 18;
  localparam int PAGE_LSB = 0;
  localparam int PAGE_MSB = 5;
  localparam int BLOCK_LSB = 6;
  localparam int BLOCK_MSB = 17;

  // ----------------------------------------------------------------
  // Commands
  // ----------------------------------------------------------------
  localparam logic [7:0] CMD_DTR_QUAD_READ = 8'h_EE;
  localparam logic [7:0] CMD_READ_X2 = 8'h_3B;
  localparam logic [7:0] CMD_READ_DUAL_IO = 8'h_BB;
  localparam logic [7:0] CMD_READ_X4 = 8'h_6B;
  localparam logic [7:0] CMD_READ_QUAD_IO = 8'h_EB;
  localparam logic [7:0] CMD_PROG_X4 = 8'h_32;
  localparam logic [7:0] CMD_PROG_RAND_X4A = 8'h_C4;
  localparam logic [7:0] CMD_PROG_RAND_X4B = 8'h_34;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0] RESET_COMMAND = 8'h_00;
  localparam logic [4:0] RESET_PROTECT = 5'h_00;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {SNBFE_X1, SNBFE_X2, SNBFE_X4} snbfe_width_t;
  typedef enum {SNBFE_IDLE, SNBFE_CMD, SNBFE_DATA} snbfe_state_t;

endpackage

// ---- core/snbfe_fifo.sv ----
// Synchronous FIFO holding received data bytes on their way to the core.
// Assumes one clock and a synchronous active-low reset.
module snbfe_fifo
  import snbfe_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic inValid,
  output logic inReady,
  input wire logic [WIDTH-1:0] inData,
  output logic outValid,
  input wire logic outReady,
  output logic [WIDTH-1:0] outData
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0] wrPtr;
  logic [AW:0] rdPtr;
  wire full = (wrPtr[AW] != rdPtr[AW]) && (wrPtr[AW-1:0] == rdPtr[AW-1:0]);
  wire empty = (wrPtr == rdPtr);
  wire doWrite = inValid && !full;
  wire doRead = outReady && !empty;

  assign inReady = !full;
  assign outValid = !empty;
  assign outData = store[rdPtr[AW-1:0]];

  always_ff @(posedge clk) begin
    if (doWrite) begin
      store[wrPtr[AW-1:0]] <= inData;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      wrPtr <= '0;
      rdPtr <= '0;
    end else begin
      if (doWrite) begin
        wrPtr <= wrPtr + 1'b1;
      end
      if (doRead) begin
        rdPtr <= rdPtr + 1'b1;
      end
    end
  end

endmodule // snbfe_fifo

// ---- core/snbfe_front_end.sv ----
// Serial bus front end: pin roles, pause, protect gating, strobe, address map.
// Assumes the host serial clock and pins are asynchronous to clk and slow
// enough to be oversampled; the core supplies width, data and mode decisions.
// How it works
// - Chip select is active low; high means not addressed.
// - Column offsets above 2175, or above 2111 when programming with ECC on, are flagged invalid.
// - Row bits 5..0 give the page, bits 17..6 give the block.
// - With ECC on, only first 64 spare bytes accept programming; all read.
// - With ECC off, all 128 spare bytes are readable and programmable.
// - Only clock modes 0 and 3 are supported.
// - Input sampled on rising serial clock, output changed on falling.
// - Two-bit commands make lines 0 and 1 bidirectional data.
// - Four-bit commands also turn protect and pause pins into lines 2, 3.
// - Double-rate quad read uses both edges and needs quad enable set.
// - Pause works only while quad enable is zero.
// - Pause stops only the serial link, not internal operations.
// - Pause enters/exits on pause pin edges, deferred while clock is high.
// - During pause the output floats and input and clock are ignored.
// - Chip select rising during pause resets the interface.
// - Protect-bit writes refused when write disable set and protect pin low.
// - Pin write protection acts only while quad enable is zero.
// - Strobe is used only for the double-rate quad read command.
// - Strobe held low after that command, toggles with clock when data valid.
module snbfe_front_end
  import snbfe_pkg::*;
#(
  parameter int FIFO_DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  // Pins.
  input wire logic serialClock,
  input wire logic chipSelect_n,
  input wire logic [3:0] dataLineIn,
  output logic [3:0] dataLineOut,
  output logic [3:0] dataLineOe,
  output logic dataStrobe,
  output logic dataStrobeOe,
  // Configuration.
  input wire logic quad_io_enable,
  input wire logic protect_bits_write_disable,
  input wire logic eccEnable,
  // Core side: outgoing data.
  input wire logic [7:0] txData,
  input wire logic txValid,
  output logic txReady,
  input wire logic txDoubleRate,
  input wire logic [1:0] txWidth,
  // Core side: received bytes.
  output logic [7:0] rxData,
  output logic rxValid,
  input wire logic rxReady,
  output logic rxFirst,
  output logic overflow,
  // Core side: status.
  output logic [7:0] command,
  output logic commandValid,
  output logic paused,
  output logic selected,
  output logic protectWriteAllowed,
  // Address map checks.
  input wire logic [11:0] column_address,
  input wire logic [17:0] row_address,
  input wire logic programAccess,
  output logic columnValid,
  output logic [5:0] pageIndex,
  output logic [11:0] blockIndex
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sclkSync;
  logic [1:0] csSync;
  logic [3:0] dinMeta;
  logic [3:0] dinSync;
  logic sclkLast;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      sclkSync <= 2'b00;
      csSync <= 2'b11;
      dinMeta <= 4'h_f;
      dinSync <= 4'h_f;
      sclkLast <= 1'b0;
    end else begin
      sclkSync <= {sclkSync[0], serialClock};
      csSync <= {csSync[0], chipSelect_n};
      dinMeta <= dataLineIn;
      dinSync <= dinMeta;
      sclkLast <= sclkSync[1];
    end
  end

  wire sclk = sclkSync[1];
  wire csHigh = csSync[1];
  wire rise = sclk && !sclkLast;
  wire fall = !sclk && sclkLast;
  wire pausePin = dinSync[3];
  wire protectPin = dinSync[2];

  // ----------------------------------------------------------------
  // Pause control
  // ----------------------------------------------------------------
  logic pauseActive;
  wire pauseAllowed = !quad_io_enable;
  wire next_pauseActive = csHigh ? 1'b0 :
                          !pauseAllowed ? 1'b0 :
                          sclk ? pauseActive :
                          !pausePin;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      pauseActive <= 1'b0;
    end else begin
      pauseActive <= next_pauseActive;
    end
  end

  // Edges seen while paused are dropped; internal work is not touched.
  wire sampleEdge = rise && !pauseActive && !csHigh;
  wire shiftEdge = fall && !pauseActive && !csHigh;

  // ----------------------------------------------------------------
  // Command and data shifter
  // ----------------------------------------------------------------
  snbfe_state_t state;
  snbfe_state_t next_state;
  logic [7:0] shiftIn;
  logic [2:0] bitCount;
  logic firstByte;
  snbfe_width_t rxWidth;

  function automatic snbfe_width_t widthOf(input logic [7:0] cmd);
    case (cmd)
      CMD_READ_X2, CMD_READ_DUAL_IO: widthOf = SNBFE_X2;
      CMD_READ_X4, CMD_READ_QUAD_IO, CMD_PROG_X4, CMD_PROG_RAND_X4A,
      CMD_PROG_RAND_X4B, CMD_DTR_QUAD_READ: widthOf = SNBFE_X4;
      default: widthOf = SNBFE_X1;
    endcase
  endfunction

  function automatic logic [2:0] stepOf(input snbfe_width_t w);
    case (w)
      SNBFE_X2: stepOf = 3'd2;
      SNBFE_X4: stepOf = 3'd4;
      default: stepOf = 3'd1;
    endcase
  endfunction

  wire [2:0] step = stepOf(rxWidth);
  wire [7:0] shiftNext = (rxWidth == SNBFE_X4) ? {shiftIn[3:0], dinSync[3:0]} :
                         (rxWidth == SNBFE_X2) ? {shiftIn[5:0], dinSync[1:0]} :
                         {shiftIn[6:0], dinSync[0]};
  wire [3:0] countSum = {1'b0, bitCount} + {1'b0, step};
  wire byteDone = sampleEdge && countSum[3];
  wire isDtr = (command == CMD_DTR_QUAD_READ) && commandValid;
  wire dtrLegal = quad_io_enable;
  wire fifoInReady;

  always_comb begin
    next_state = state;
    case (state)
      SNBFE_IDLE: begin
        if (!csHigh) begin
          next_state = SNBFE_CMD;
        end
      end
      SNBFE_CMD: begin
        if (byteDone) begin
          next_state = SNBFE_DATA;
        end
      end
      SNBFE_DATA: next_state = SNBFE_DATA;
      default: next_state = SNBFE_IDLE;
    endcase
    if (csHigh) begin
      next_state = SNBFE_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      state <= SNBFE_IDLE;
      shiftIn <= 8'h_00;
      bitCount <= 3'd0;
      command <= RESET_COMMAND;
      commandValid <= 1'b0;
      firstByte <= 1'b0;
      rxWidth <= SNBFE_X1;
      overflow <= 1'b0;
    end else begin
      state <= next_state;
      if (csHigh) begin
        bitCount <= 3'd0;
        commandValid <= 1'b0;
        rxWidth <= SNBFE_X1;
      end else if (sampleEdge) begin
        shiftIn <= shiftNext;
        bitCount <= countSum[2:0];
        if (byteDone && state == SNBFE_CMD) begin
          command <= shiftNext;
          commandValid <= 1'b1;
          rxWidth <= widthOf(shiftNext);
          firstByte <= 1'b1;
        end else if (byteDone) begin
          firstByte <= 1'b0;
        end
      end
      if (byteDone && state == SNBFE_DATA && !fifoInReady) begin
        overflow <= 1'b1;
      end else if (csHigh) begin
        overflow <= 1'b0;
      end
    end
  end

  snbfe_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .inValid(byteDone && state == SNBFE_DATA),
    .inReady(fifoInReady),
    .inData(shiftNext),
    .outValid(rxValid),
    .outReady(rxReady),
    .outData(rxData)
  );

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      rxFirst <= 1'b0;
    end else begin
      rxFirst <= firstByte;
    end
  end

  // ----------------------------------------------------------------
  // Output driver
  // ----------------------------------------------------------------
  logic [7:0] txShift;
  logic [2:0] txCount;
  logic txLoaded;
  logic strobe;
  logic [3:0] doutReg;
  // Reserved core input; the strobe mode follows the accepted command instead.
  logic txDoubleUnused;
  wire [2:0] txStep = stepOf(snbfe_width_t'(txWidth));
  wire dtrActive = isDtr && dtrLegal;
  wire txEdge = dtrActive ? ((fall || rise) && !pauseActive && !csHigh) : shiftEdge;
  wire [3:0] txSum = {1'b0, txCount} + {1'b0, txStep};

  assign txReady = !txLoaded && !csHigh;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txShift <= 8'h_00;
      txCount <= 3'd0;
      txLoaded <= 1'b0;
      doutReg <= 4'h_0;
      strobe <= 1'b0;
    end else if (csHigh) begin
      txLoaded <= 1'b0;
      txCount <= 3'd0;
      strobe <= 1'b0;
    end else begin
      if (txValid && txReady) begin
        txShift <= txData;
        txLoaded <= 1'b1;
        txCount <= 3'd0;
      end else if (txLoaded && txEdge) begin
        case (snbfe_width_t'(txWidth))
          SNBFE_X4: doutReg <= txShift[7:4];
          SNBFE_X2: doutReg <= {2'b00, txShift[7:6]};
          default: doutReg <= {2'b00, txShift[7], 1'b0};
        endcase
        txShift <= txShift << txStep;
        txCount <= txSum[2:0];
        if (txSum[3]) begin
          txLoaded <= 1'b0;
        end
      end
      if (dtrActive && txLoaded && txEdge) begin
        strobe <= !strobe;
      end else if (!dtrActive) begin
        strobe <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Last bit hold
  // ----------------------------------------------------------------
  // The final bit of a byte stays on its lines until the next shift edge.
  logic txHold;

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      txHold <= 1'b0;
    end else if (csHigh) begin
      txHold <= 1'b0;
    end else if (txLoaded && txEdge && txSum[3]) begin
      txHold <= 1'b1;
    end else if (txEdge) begin
      txHold <= 1'b0;
    end
  end

  // Lines are driven only while selected, unpaused and in the data phase.
  wire driving = !csHigh && !pauseActive && state == SNBFE_DATA;
  wire [3:0] laneMask = (txWidth == 2'(SNBFE_X4)) ? 4'h_f :
                        (txWidth == 2'(SNBFE_X2)) ? 4'h_3 : 4'h_2;

  assign dataLineOut = doutReg;
  assign dataLineOe = (driving && (txLoaded || txHold)) ? laneMask : 4'h_0;
  assign dataStrobe = strobe;
  assign dataStrobeOe = isDtr && !csHigh;
  assign paused = pauseActive;
  assign selected = !csHigh;
  assign txDoubleUnused = txDoubleRate;

  // ----------------------------------------------------------------
  // Protection and address map
  // ----------------------------------------------------------------
  wire pinProtects = !quad_io_enable && !protectPin;
  assign protectWriteAllowed = !(protect_bits_write_disable && pinProtects);

  wire [11:0] colLast = eccEnable ? COL_LAST_ECC_ON : COL_LAST_ECC_OFF;
  wire inRange = column_address <= colLast;
  wire spareProgBlocked = eccEnable && programAccess &&
                          column_address > SPARE_PROG_LAST_ECC_ON;
  wire spareReadAll = !programAccess && column_address >= SPARE_FIRST &&
                      column_address <= COL_LAST_ECC_OFF;
  assign columnValid = (inRange && !spareProgBlocked) || spareReadAll;
  assign pageIndex = row_address[PAGE_MSB:PAGE_LSB];
  assign blockIndex = row_address[BLOCK_MSB:BLOCK_LSB];

endmodule // snbfe_front_end

// ---- verification/snbfe_properties.sv ----
// Checker of the front end's port behaviour.
// Assumes it is bound to snbfe_front_end and sees only its ports.
module snbfe_properties
  import snbfe_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic chipSelect_n,
  input wire logic [3:0] dataLineIn,
  input wire logic [3:0] dataLineOe,
  input wire logic dataStrobe,
  input wire logic dataStrobeOe,
  input wire logic quad_io_enable,
  input wire logic protect_bits_write_disable,
  input wire logic eccEnable,
  input wire logic [7:0] command,
  input wire logic commandValid,
  input wire logic paused,
  input wire logic protectWriteAllowed,
  input wire logic [11:0] column_address,
  input wire logic [17:0] row_address,
  input wire logic programAccess,
  input wire logic columnValid,
  input wire logic [5:0] pageIndex,
  input wire logic [11:0] blockIndex
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  wire lock = protect_bits_write_disable && !dataLineIn[2] && !quad_io_enable;
  wire [11:0] colLast = (eccEnable && programAccess) ? 12'h83F : 12'h87F;
  property p_float; chipSelect_n [*5] |-> dataLineOe == 4'h0; endproperty
  a_float: assert property (p_float) else $error("Lines driven while idle.");
  property p_drop; chipSelect_n [*5] |-> !commandValid; endproperty
  a_drop: assert property (p_drop) else $error("Command kept while idle.");
  property p_hold_float; paused |-> dataLineOe == 4'h0; endproperty
  a_hold_float: assert property (p_hold_float) else $error("Output driven in pause.");
  property p_hold_quad; quad_io_enable [*4] |-> !paused; endproperty
  a_hold_quad: assert property (p_hold_quad) else $error("Pause with quad on.");
  property p_hold_cs; chipSelect_n [*5] |-> !paused; endproperty
  a_hold_cs: assert property (p_hold_cs) else $error("Pause kept after deselect.");
  property p_lock; lock [*4] |-> !protectWriteAllowed; endproperty
  a_lock: assert property (p_lock) else $error("Protect write not locked.");
  property p_open; !lock [*4] |-> protectWriteAllowed; endproperty
  a_open: assert property (p_open) else $error("Protect write wrongly locked.");
  property p_col; columnValid == (column_address <= colLast); endproperty
  a_col: assert property (p_col) else $error("Column check wrong.");
  property p_row; pageIndex == row_address[5:0] && blockIndex == row_address[17:6]; endproperty
  a_row: assert property (p_row) else $error("Row split wrong.");
  property p_dqs; dataStrobeOe |-> commandValid && command == CMD_DTR_QUAD_READ; endproperty
  a_dqs: assert property (p_dqs) else $error("Strobe on wrong command.");
  property p_dqs_low; $rose(dataStrobeOe) |-> !dataStrobe; endproperty
  a_dqs_low: assert property (p_dqs_low) else $error("Strobe not low at start.");
endmodule // snbfe_properties

bind snbfe_front_end snbfe_properties u_props (
  .clk(clk),
  .reset_n(reset_n),
  .chipSelect_n(chipSelect_n),
  .dataLineIn(dataLineIn),
  .dataLineOe(dataLineOe),
  .dataStrobe(dataStrobe),
  .dataStrobeOe(dataStrobeOe),
  .quad_io_enable(quad_io_enable),
  .protect_bits_write_disable(protect_bits_write_disable),
  .eccEnable(eccEnable),
  .command(command),
  .commandValid(commandValid),
  .paused(paused),
  .protectWriteAllowed(protectWriteAllowed),
  .column_address(column_address),
  .row_address(row_address),
  .programAccess(programAccess),
  .columnValid(columnValid),
  .pageIndex(pageIndex),
  .blockIndex(blockIndex)
);

// ---- verification/snbfe_host_model.sv ----
// Host controller model driving the serial pins, mode 0 or mode 3.
// Assumes clk runs at 50 ns; one serial half period is four clk cycles.
module snbfe_host_model (
  input wire logic clk,
  input wire logic [3:0] dataLineOut,
  input wire logic [3:0] dataLineOe,
  output logic serialClock,
  output logic chipSelect_n,
  output logic [3:0] dataLineIn
);
  timeunit 1ns;
  timeprecision 100ps;
  logic mode3 = 1'b0;
  logic [7:0] got;
  initial begin
    chipSelect_n = 1'b1;
    serialClock = 1'b0;
    dataLineIn = 4'hF;
  end
  task automatic half();
    repeat (4) @(posedge clk);
    #1;
  endtask
  task automatic sel(input logic m3);
    mode3 = m3;
    serialClock = m3;
    half();
    chipSelect_n = 1'b0;
    half();
  endtask
  task automatic desel();
    serialClock = mode3;
    half();
    chipSelect_n = 1'b1;
    dataLineIn[0] = ~dataLineIn[0];
    half();
  endtask
  // Shifts a byte out on line 0 and captures line 1, MSB first.
  task automatic xfer(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      serialClock = 1'b0;
      dataLineIn[0] = b[i];
      half();
      serialClock = 1'b1;
      half();
      got[i] = dataLineOe[1] ? dataLineOut[1] : 1'bx;
    end
  endtask
endmodule // snbfe_host_model

// ---- verification/tb_serial_nand_bus_front_end.sv ----
// Self-checking bench of the serial front end.
// Assumes the host model drives the pins and the core side is driven here.
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin failCount++; \
  $display("[FAIL] t=%0t got %h exp %h", $time, a, e); end end
module tb_serial_nand_bus_front_end
  import snbfe_pkg::*;
;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk;
  logic reset_n;
  logic serialClock, chipSelect_n, dataStrobe, dataStrobeOe, txReady;
  logic rxValid, rxFirst, overflow, commandValid, paused, selected;
  logic protectWriteAllowed, columnValid;
  logic [3:0] dataLineIn, dataLineOut, dataLineOe;
  logic quad_io_enable;
  logic protect_bits_write_disable;
  logic eccEnable;
  logic txValid;
  logic txDoubleRate;
  logic rxReady;
  logic programAccess;
  logic [1:0] txWidth;
  logic [7:0] txData;
  logic [7:0] rxData, command;
  logic [11:0] column_address;
  logic [11:0] blockIndex;
  logic [17:0] row_address;
  logic [5:0] pageIndex;
  logic [11:0] cols [5] = '{12'h83F, 12'h840, 12'h87F, 12'h880, 12'hFFF};
  int failCount = 0;
  int checked = 0;
  always #25 clk = ~clk;
  snbfe_front_end #(.FIFO_DEPTH(8)) DUT (
    .clk(clk),
    .reset_n(reset_n),
    .serialClock(serialClock),
    .chipSelect_n(chipSelect_n),
    .dataLineIn(dataLineIn),
    .dataLineOut(dataLineOut),
    .dataLineOe(dataLineOe),
    .dataStrobe(dataStrobe),
    .dataStrobeOe(dataStrobeOe),
    .quad_io_enable(quad_io_enable),
    .protect_bits_write_disable(protect_bits_write_disable),
    .eccEnable(eccEnable),
    .txData(txData),
    .txValid(txValid),
    .txReady(txReady),
    .txDoubleRate(txDoubleRate),
    .txWidth(txWidth),
    .rxData(rxData),
    .rxValid(rxValid),
    .rxReady(rxReady),
    .rxFirst(rxFirst),
    .overflow(overflow),
    .command(command),
    .commandValid(commandValid),
    .paused(paused),
    .selected(selected),
    .protectWriteAllowed(protectWriteAllowed),
    .column_address(column_address),
    .row_address(row_address),
    .programAccess(programAccess),
    .columnValid(columnValid),
    .pageIndex(pageIndex),
    .blockIndex(blockIndex)
  );
  snbfe_host_model host (
    .clk(clk),
    .dataLineOut(dataLineOut),
    .dataLineOe(dataLineOe),
    .serialClock(serialClock),
    .chipSelect_n(chipSelect_n),
    .dataLineIn(dataLineIn)
  );
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", checked, failCount);
    if (failCount == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic t_rx(input logic m3);
    host.sel(m3);
    `CHK(selected, 1'b1)
    host.xfer(8'h02);
    tick(3);
    `CHK(command, 8'h02)
    `CHK(rxFirst, 1'b1)
    host.xfer(8'hA5);
    tick(3);
    `CHK(rxData, 8'hA5)
    `CHK(rxFirst, 1'b0)
    rxReady = 1'b1;
    tick(1);
    rxReady = 1'b0;
    `CHK(rxValid, 1'b0)
    host.desel();
    `CHK(commandValid, 1'b0)
    `CHK(selected, 1'b0)
    $display("receive test done");
  endtask
  task automatic t_fifo();
    host.sel(1'b0);
    host.xfer(8'h84);
    for (int i = 0; i < 9; i++) host.xfer(8'h10 + 8'(i));
    tick(3);
    `CHK(overflow, 1'b1)
    rxReady = 1'b1;
    for (int i = 0; i < 8; i++) begin
      `CHK(rxData, 8'h10 + 8'(i))
      tick(1);
    end
    rxReady = 1'b0;
    `CHK(rxValid, 1'b0)
    host.desel();
    `CHK(overflow, 1'b0)
    $display("fifo test done");
  endtask
  task automatic t_pause();
    host.sel(1'b0);
    host.xfer(8'h02);
    host.dataLineIn[3] = 1'b0;
    tick(4);
    `CHK(paused, 1'b0)
    host.serialClock = 1'b0;
    tick(4);
    `CHK(paused, 1'b1)
    host.xfer(8'h5A);
    host.dataLineIn[3] = 1'b1;
    tick(4);
    `CHK(paused, 1'b1)
    host.serialClock = 1'b0;
    tick(4);
    `CHK(paused, 1'b0)
    host.xfer(8'h33);
    tick(3);
    `CHK(rxData, 8'h33)
    rxReady = 1'b1;
    tick(1);
    rxReady = 1'b0;
    host.dataLineIn[3] = 1'b0;
    host.desel();
    `CHK(paused, 1'b0)
    host.dataLineIn[3] = 1'b1;
    quad_io_enable = 1'b1;
    host.sel(1'b0);
    host.dataLineIn[3] = 1'b0;
    tick(4);
    `CHK(paused, 1'b0)
    host.dataLineIn[3] = 1'b1;
    host.desel();
    quad_io_enable = 1'b0;
    $display("pause test done");
  endtask
  task automatic t_prot();
    logic [2:0] c;
    for (int i = 0; i < 8; i++) begin
      c = 3'(i);
      protect_bits_write_disable = c[0];
      host.dataLineIn[2] = c[1];
      quad_io_enable = c[2];
      tick(4);
      `CHK(protectWriteAllowed, !(c[0] && !c[1] && !c[2]))
    end
    quad_io_enable = 1'b0;
    host.dataLineIn[2] = 1'b1;
    $display("protect test done");
  endtask
  task automatic t_addr();
    for (int i = 0; i < 20; i++) begin
      column_address = cols[i % 5];
      eccEnable = (i / 5) % 2;
      programAccess = i / 10;
      tick(1);
      `CHK(columnValid, cols[i % 5] <= ((eccEnable && programAccess) ? 12'h83F : 12'h87F))
    end
    `CHK(pageIndex, 6'h1D)
    `CHK(blockIndex, 12'hAAD)
    row_address = 18'h1_0FC0;
    tick(1);
    `CHK(pageIndex, 6'h00)
    `CHK(blockIndex, 12'h43F)
    $display("address test done");
  endtask
  task automatic t_dtr();
    quad_io_enable = 1'b1;
    host.sel(1'b0);
    host.xfer(8'h6B);
    tick(3);
    `CHK(dataStrobeOe, 1'b0)
    host.desel();
    host.sel(1'b0);
    host.xfer(CMD_DTR_QUAD_READ);
    tick(3);
    `CHK(dataStrobeOe, 1'b1)
    `CHK(dataStrobe, 1'b0)
    host.desel();
    `CHK(dataStrobeOe, 1'b0)
    quad_io_enable = 1'b0;
    $display("strobe test done");
  endtask
  task automatic t_tx();
    host.sel(1'b0);
    host.xfer(8'h03);
    txData = 8'hC3;
    txValid = 1'b1;
    for (int i = 0; i < 8 && txReady !== 1'b1; i++) tick(1);
    tick(1);
    txValid = 1'b0;
    host.xfer(8'h00);
    `CHK(host.got, 8'hC3)
    host.desel();
    `CHK(dataLineOe, 4'h0)
    $display("transmit test done");
  endtask
  task automatic t_wide(input logic [1:0] w, input logic [3:0] mask, input logic [3:0] first);
    host.sel(1'b0);
    host.xfer(CMD_READ_X4);
    txWidth = w;
    txData = 8'h5A;
    txValid = 1'b1;
    `CHK(txReady, 1'b1)
    tick(1);
    txValid = 1'b0;
    `CHK(txReady, 1'b0)
    `CHK(dataLineOe, mask)
    host.serialClock = 1'b0;
    tick(4);
    `CHK(dataLineOut, first)
    host.desel();
    `CHK(dataLineOe, 4'h0)
    txWidth = 2'h0;
    $display("wide transmit test done");
  endtask
  initial begin
    #1000000;
    failCount++;
    summarize();
  end
  initial begin
    clk = 1'b0;
    reset_n = 1'b0;
    quad_io_enable = 1'b0;
    protect_bits_write_disable = 1'b0;
    eccEnable = 1'b0;
    txValid = 1'b0;
    txDoubleRate = 1'b0;
    rxReady = 1'b0;
    programAccess = 1'b0;
    txWidth = 2'h0;
    txData = 8'h00;
    column_address = 12'h000;
    row_address = 18'h2_AB5D;
    tick(4);
    reset_n = 1'b1;
    tick(3);
    t_rx(1'b0);
    t_rx(1'b1);
    t_fifo();
    t_pause();
    t_prot();
    t_addr();
    t_dtr();
    t_tx();
    t_wide(2'h2, 4'hF, 4'h5);
    t_wide(2'h1, 4'h3, 4'h1);
    summarize();
  end
endmodule // tb_serial_nand_bus_front_end
